/* File: logic/mlt_core.sv */
/*
 mlt_core: execution of literal, bank, pointer, table, add-to-file,
 bit-clear and branch-if-negative instructions, with its register port.
 assumes: fetch logic on mclk_i offers words with a valid flag and the
 word's address; file memory answers reads in the same cycle.
*/
// Chosen here: the plain strobed port and the register offsets.
// Contract
// (RQ1) add literal to working register, flags N OV C DC Z, one cycle
// (RQ2) and literal into working register, only Z and N change
// (RQ3) or and xor literal into working register, only Z and N change
// (RQ4) literal minus working register, flags C DC Z OV N
// (RQ5) move literal to working register, no flag changes
// (RQ6) multiply literal by working register, one cycle, no flags
// (RQ7) four-bit literal into bank select register bits 3..0
// (RQ8) two-word load of a 12-bit literal into a file select pointer
// (RQ9) return with literal in working register, two cycles, no flags
// (RQ10) table reads with none, post-inc, post-dec, pre-inc pointer
// (RQ11) table writes with the same four pointer modes, two cycles
// (RQ12) a started memory write cycle runs until terminated
// (RQ13) port read-modify-write takes pin levels as source
// (RQ14) writing timer zero count clears an assigned prescaler
// (RQ15) program counter change or true test costs a nop cycle
// (RQ16) a lone second word executes as a nop
// (RQ17) add working register to file, d picks destination
// (RQ18) a=0 forces access bank, a=1 uses bank select register
// (RQ19) extended set, a=0, f up to 5Fh means indexed offset
// (RQ20) branch if N set, offset -128..127, one or two cycles
// (RQ21) branch target is instruction address plus 2 plus 2n
// (RQ22) clear bit b of file f, no flags
// (RQ23) product kept in separate high and low byte registers
`timescale 1ns/1ns
`default_nettype none
module mlt_core
    import mlt_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // instruction stream
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [20:0] instr_pc_i,
    output logic instr_ready_o,
    // file registers and pins
    output logic [11:0] file_raddr_o,
    input wire logic [7:0] file_rdata_i,
    output mlt_fwr_type file_wr_o,
    input wire logic [7:0] port_pins_i,
    output logic presc_clr_o,
    // program flow
    output logic pc_load_o,
    output logic [20:0] pc_target_o,
    output logic return_o,
    // table access
    output logic tbl_rd_o,
    output logic tbl_wr_o,
    output logic [20:0] tbl_addr_o,
    output logic [7:0] tbl_wdata_o,
    input wire logic [7:0] tbl_rdata_i,
    output logic mem_wr_active_o,
    input wire logic mem_wr_done_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [23:0] reg_rdata_o
);
    mlt_state_type state;
    logic [7:0] work;
    logic [7:0] next_work;
    logic [3:0] bank;
    logic [3:0] next_bank;
    logic [4:0] stat;
    logic [4:0] next_stat;
    logic [15:0] prod;
    logic [15:0] next_prod;
    logic [1:0] ctrl;
    logic [20:0] tblptr;
    logic [20:0] next_tblptr;
    logic [7:0] tblat;
    logic [11:0] ptr [3];
    logic [5:0] lp_first;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] src;
    logic [7:0] k;
    logic go;
    logic two;
    logic lp_start;
    logic ret;
    logic pc_ld;
    logic [20:0] pc_tgt;
    logic tb_rd;
    logic tb_wr;
    logic [20:0] tb_addr;
    logic wr_bus;
    mlt_fwr_type next_fwr;
    mlt_alu_type alu;

    function automatic mlt_alu_type add8(input logic [7:0] x, input logic [7:0] y,
                                         input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        mlt_alu_type r;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        r.sum = s[7:0];
        r.c = s[8];
        r.dc = h[4];
        r.ov = (x[7] == y[7]) && (s[7] != x[7]);
        return r;
    endfunction

    function automatic logic [4:0] arith_flags(input mlt_alu_type r);
        logic [4:0] f;
        f = '0;
        f[ST_C] = r.c;
        f[ST_DC] = r.dc;
        f[ST_OV] = r.ov;
        f[ST_Z] = (r.sum == 8'h00);
        f[ST_N] = r.sum[7];
        return f;
    endfunction

    function automatic logic [4:0] logic_flags(input logic [4:0] old, input logic [7:0] v);
        logic [4:0] f;
        f = old;
        f[ST_Z] = (v == 8'h00);
        f[ST_N] = v[7];
        return f;
    endfunction

    assign go = instr_valid_i && (state == ST_EXEC);
    assign k = instr_i[7:0];
    assign instr_ready_o = (state != ST_NOP);
    assign wr_bus = reg_wr_i;

    // pins pass two flops before use
    always_ff @(posedge mclk_i)
    begin
        pin_s1 <= port_pins_i;
        pin_s2 <= pin_s1;
    end

    // file address from a, f and extended mode
    always_comb
    begin
        file_raddr_o = {bank, k};
        if (!instr_i[8])
        begin
            // (RQ19) indexed literal offset
            if (ctrl[CTRL_EXT] && k <= IDX_LIMIT)
                file_raddr_o = ptr[2] + {4'h0, k};
            // (RQ18) access bank split
            else if (k < ACCESS_SPLIT)
                file_raddr_o = {4'h0, k};
            else
                file_raddr_o = {ACCESS_HI, k};
        end
    end

    // (RQ13) port source is pin level
    assign src = (file_raddr_o == PORT_ADDR) ? pin_s2 : file_rdata_i;

    always_comb
    begin
        next_work = (wr_bus && reg_addr_i == RA_WORK) ? reg_wdata_i[7:0] : work;
        next_bank = (wr_bus && reg_addr_i == RA_BANK) ? reg_wdata_i[3:0] : bank;
        next_stat = (wr_bus && reg_addr_i == RA_STAT) ? reg_wdata_i[4:0] : stat;
        next_prod = prod;
        next_tblptr = (wr_bus && reg_addr_i == RA_TBLPTR) ? reg_wdata_i[20:0] : tblptr;
        next_fwr = '0;
        alu = add8(work, k, 1'b0);
        two = 1'b0;
        lp_start = 1'b0;
        ret = 1'b0;
        pc_ld = 1'b0;
        pc_tgt = instr_pc_i + PC_STEP + {{12{k[7]}}, k, 1'b0};
        tb_rd = 1'b0;
        tb_wr = 1'b0;
        tb_addr = tblptr;
        if (go)
        begin
            if (instr_i[15:8] == OP_ADD_LIT)
            begin
                // (RQ1) add literal
                next_work = alu.sum;
                next_stat = arith_flags(alu);
            end
            else if (instr_i[15:8] == OP_SUB_LIT)
            begin
                // (RQ4) literal minus working
                alu = add8(k, ~work, 1'b1);
                next_work = alu.sum;
                next_stat = arith_flags(alu);
            end
            else if (instr_i[15:8] == OP_AND_LIT)
            begin
                // (RQ2) and literal
                next_work = work & k;
                next_stat = logic_flags(stat, work & k);
            end
            else if (instr_i[15:8] == OP_OR_LIT)
            begin
                // (RQ3) or literal
                next_work = work | k;
                next_stat = logic_flags(stat, work | k);
            end
            else if (instr_i[15:8] == OP_XOR_LIT)
            begin
                // (RQ3) xor literal
                next_work = work ^ k;
                next_stat = logic_flags(stat, work ^ k);
            end
            else if (instr_i[15:8] == OP_MOVE_LIT)
                // (RQ5) move literal
                next_work = k;
            else if (instr_i[15:8] == OP_MUL_LIT)
                // (RQ6) multiply into product pair
                next_prod = {8'h00, k} * {8'h00, work};
            else if (instr_i[15:8] == OP_BANK_LIT && instr_i[7:4] == OP_BANK_MID)
                // (RQ7) bank literal
                next_bank = instr_i[3:0];
            else if (instr_i[15:8] == OP_LOAD_PTR)
                // (RQ8) first word of pointer load
                lp_start = 1'b1;
            else if (instr_i[15:8] == OP_RET_LIT)
            begin
                // (RQ9) return with literal
                next_work = k;
                ret = 1'b1;
                two = 1'b1;
            end
            else if (instr_i[15:4] == OP_TABLE && instr_i[3])
            begin
                // (RQ10) (RQ11) pointer mode from low two bits
                two = 1'b1;
                tb_rd = !instr_i[2];
                tb_wr = instr_i[2];
                if (instr_i[1:0] == 2'b11)
                    tb_addr = tblptr + 21'h000001;
                if (instr_i[1:0] == 2'b10)
                    next_tblptr = tblptr - 21'h000001;
                else if (instr_i[1:0] != 2'b00)
                    next_tblptr = tblptr + 21'h000001;
            end
            else if (instr_i[15:10] == OP_ADD_FILE)
            begin
                // (RQ17) add working to file
                alu = add8(work, src, 1'b0);
                next_stat = arith_flags(alu);
                if (instr_i[9])
                    next_fwr = '{we: 1'b1, addr: file_raddr_o, data: alu.sum};
                else
                    next_work = alu.sum;
            end
            else if (instr_i[15:12] == OP_BIT_CLR)
                // (RQ22) clear one bit
                next_fwr = '{we: 1'b1, addr: file_raddr_o,
                             data: src & ~(8'h01 << instr_i[11:9])};
            else if (instr_i[15:8] == OP_BR_NEG && stat[ST_N])
            begin
                // (RQ20) (RQ21) taken branch
                pc_ld = 1'b1;
                two = 1'b1;
            end
            // (RQ16) a lone second word matches nothing above
        end
    end

    // (RQ15) (RQ8) sequencing of extra cycles
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            state <= ST_EXEC;
        else
            unique case (state)
                ST_EXEC:
                    if (lp_start)
                        state <= ST_WORD2;
                    else if (two)
                        state <= ST_NOP;
                ST_NOP:
                    state <= ST_EXEC;
                ST_WORD2:
                    if (instr_valid_i)
                        state <= ST_EXEC;
            endcase
    end

    // core registers
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            work <= 8'h00;
            bank <= 4'h0;
            stat <= STAT_RESET;
            prod <= 16'h0000;
            tblptr <= 21'h000000;
        end
        else
        begin
            work <= next_work;
            bank <= next_bank;
            stat <= next_stat;
            prod <= next_prod;
            tblptr <= next_tblptr;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            ctrl <= CTRL_RESET;
        else if (wr_bus && reg_addr_i == RA_CTRL)
            ctrl <= reg_wdata_i[1:0];
    end

    // (RQ8) pointer load on second word
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            lp_first <= 6'h00;
            ptr <= '{default: 12'h000};
        end
        else
        begin
            if (lp_start)
                lp_first <= instr_i[5:0];
            if (state == ST_WORD2 && instr_valid_i && instr_i[15:8] == OP_LOAD_PTR2
                && lp_first[5:4] != 2'b11)
                ptr[lp_first[5:4]] <= {lp_first[3:0], k};
        end
    end

    // table latch: software or read data
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tblat <= 8'h00;
        else if (tbl_rd_o)
            tblat <= tbl_rdata_i;
        else if (wr_bus && reg_addr_i == RA_TBLAT)
            tblat <= reg_wdata_i[7:0];
    end

    // (RQ12) write cycle held until done, start wins
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            mem_wr_active_o <= 1'b0;
        else if (tb_wr)
            mem_wr_active_o <= 1'b1;
        else if (mem_wr_done_i)
            mem_wr_active_o <= 1'b0;
    end

    // registered outputs
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            file_wr_o <= '0;
            presc_clr_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_target_o <= 21'h000000;
            return_o <= 1'b0;
            tbl_rd_o <= 1'b0;
            tbl_wr_o <= 1'b0;
            tbl_addr_o <= 21'h000000;
            tbl_wdata_o <= 8'h00;
        end
        else
        begin
            file_wr_o <= next_fwr;
            // (RQ14) prescaler clear on timer write
            presc_clr_o <= next_fwr.we && next_fwr.addr == TIMER0_ADDR && ctrl[CTRL_PSA];
            pc_load_o <= pc_ld;
            pc_target_o <= pc_tgt;
            return_o <= ret;
            tbl_rd_o <= tb_rd;
            tbl_wr_o <= tb_wr;
            tbl_addr_o <= tb_addr;
            tbl_wdata_o <= tblat;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !reg_rd_i)
            reg_rdata_o <= 24'h000000;
        else
            unique case (reg_addr_i)
                RA_WORK: reg_rdata_o <= {16'h0000, work};
                RA_BANK: reg_rdata_o <= {20'h00000, bank};
                RA_STAT: reg_rdata_o <= {19'h00000, stat};
                // (RQ23) product bytes apart
                RA_PRODL: reg_rdata_o <= {16'h0000, prod[7:0]};
                RA_PRODUCT_HIGH_BYTE: reg_rdata_o <= {16'h0000, prod[15:8]};
                RA_CTRL: reg_rdata_o <= {22'h000000, ctrl};
                RA_TBLPTR: reg_rdata_o <= {3'h0, tblptr};
                RA_TBLAT: reg_rdata_o <= {16'h0000, tblat};
                RA_PTR0: reg_rdata_o <= {12'h000, ptr[0]};
                RA_PTR1: reg_rdata_o <= {12'h000, ptr[1]};
                RA_PTR2: reg_rdata_o <= {12'h000, ptr[2]};
                RA_MEMWR: reg_rdata_o <= {23'h000000, mem_wr_active_o};
                default: reg_rdata_o <= 24'h000000;
            endcase
    end

    chk_add_lit_sum: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ1
        go && instr_i[15:8] == OP_ADD_LIT |=> work == 8'($past(work) + $past(k)))
        else $error("add literal result wrong");
    chk_and_lit_flags: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ2
        go && instr_i[15:8] == OP_AND_LIT
        |=> work == ($past(work) & $past(k)) && stat[ST_C] == $past(stat[ST_C]))
        else $error("and literal wrong");
    chk_move_lit_keep: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ5
        go && instr_i[15:8] == OP_MOVE_LIT |=> work == $past(k) && $stable(stat))
        else $error("move literal wrong");
    chk_mul_product: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ6
        go && instr_i[15:8] == OP_MUL_LIT |=> prod == 16'($past(k)) * 16'($past(work)))
        else $error("product wrong");
    chk_bank_lit_load: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ7
        go && instr_i[15:4] == {OP_BANK_LIT, OP_BANK_MID} |=> bank == $past(instr_i[3:0]))
        else $error("bank literal wrong");
    chk_branch_target: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ21
        go && instr_i[15:8] == OP_BR_NEG && stat[ST_N]
        |=> pc_load_o && !instr_ready_o
        && pc_target_o == 21'($past(instr_pc_i) + PC_STEP + 21'(2 * $signed($past(k))))
        ##1 instr_ready_o)
        else $error("branch target or timing wrong");
    chk_branch_not_taken: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ20
        go && instr_i[15:8] == OP_BR_NEG && !stat[ST_N] |=> !pc_load_o && instr_ready_o)
        else $error("untaken branch not one cycle");
    chk_bit_clear_data: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ22
        go && instr_i[15:12] == OP_BIT_CLR
        |=> file_wr_o.we && file_wr_o.data == ($past(src) & ~(8'h01 << $past(instr_i[11:9]))))
        else $error("bit clear wrong");
    chk_mem_write_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ12
        mem_wr_active_o && !mem_wr_done_i |=> mem_wr_active_o)
        else $error("memory write ended early");
    chk_lone_word_nop: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ16
        go && instr_i[15:12] == OP_SECOND && !wr_bus
        |=> $stable(work) && !file_wr_o.we && !pc_load_o)
        else $error("lone second word not a nop");
endmodule
`default_nettype wire

/* File: logic/mlt_pkg.sv */
/*
 mlt_pkg: opcodes, register indices, field positions, reset values and
 shared types of the literal, table and branch execution core.
 assumes: one 50 MHz clock, one instruction cycle per clock.
*/
`default_nettype none
package mlt_pkg;
    // opcode fields: high bytes, shorter and longer prefixes, bank middle nibble
    localparam logic [7:0] OP_ADD_LIT = 8'h0f;
    localparam logic [7:0] OP_AND_LIT = 8'h0b;
    localparam logic [7:0] OP_OR_LIT = 8'h09;
    localparam logic [7:0] OP_XOR_LIT = 8'h0a;
    localparam logic [7:0] OP_SUB_LIT = 8'h08;
    localparam logic [7:0] OP_MOVE_LIT = 8'h0e;
    localparam logic [7:0] OP_MUL_LIT = 8'h0d;
    localparam logic [7:0] OP_RET_LIT = 8'h0c;
    localparam logic [7:0] OP_BANK_LIT = 8'h01;
    localparam logic [3:0] OP_BANK_MID = 4'h0;
    localparam logic [7:0] OP_LOAD_PTR = 8'hee;
    localparam logic [7:0] OP_LOAD_PTR2 = 8'hf0;
    localparam logic [7:0] OP_BR_NEG = 8'he6;
    localparam logic [5:0] OP_ADD_FILE = 6'h09;
    localparam logic [3:0] OP_BIT_CLR = 4'h9;
    localparam logic [3:0] OP_SECOND = 4'hf;
    localparam logic [11:0] OP_TABLE = 12'h000;
    // register indices
    localparam logic [3:0] RA_WORK = 4'h0;
    localparam logic [3:0] RA_BANK = 4'h1;
    localparam logic [3:0] RA_STAT = 4'h2;
    localparam logic [3:0] RA_PRODL = 4'h3;
    localparam logic [3:0] RA_PRODUCT_HIGH_BYTE = 4'h4;
    localparam logic [3:0] RA_CTRL = 4'h5;
    localparam logic [3:0] RA_TBLPTR = 4'h6;
    localparam logic [3:0] RA_TBLAT = 4'h7;
    localparam logic [3:0] RA_PTR0 = 4'h8;
    localparam logic [3:0] RA_PTR1 = 4'h9;
    localparam logic [3:0] RA_PTR2 = 4'ha;
    localparam logic [3:0] RA_MEMWR = 4'hb;
    // status and control bits
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    localparam int CTRL_EXT = 0;
    localparam int CTRL_PSA = 1;
    localparam logic [4:0] STAT_RESET = 5'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // data memory map and program counter step
    localparam logic [11:0] PORT_ADDR = 12'hf81;
    localparam logic [11:0] TIMER0_ADDR = 12'hfd6;
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI = 4'hf;
    localparam logic [20:0] PC_STEP = 21'h000002;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } mlt_fwr_type;

    typedef struct packed {
        logic c;
        logic dc;
        logic ov;
        logic [7:0] sum;
    } mlt_alu_type;

    typedef enum logic [1:0] {ST_EXEC, ST_NOP, ST_WORD2} mlt_state_type;
endpackage
`default_nettype wire

/* File: verification/mlt_tb.sv */
/*
 tb: self-checking bench for mlt_core, driving all of its inputs.
 assumes: one 50 MHz clock; file memory and pins are modelled here.
*/
`timescale 1ns/1ns
`default_nettype none
module tb
    import mlt_pkg::*;
;
logic mclk_i = 0;
logic rst_i = 1;
logic [15:0] instr_i = '0;
logic instr_valid_i = 0;
logic [20:0] instr_pc_i = '0;
logic [7:0] file_rdata_i = '0;
logic [7:0] port_pins_i = '0;
logic [7:0] tbl_rdata_i = '0;
logic mem_wr_done_i = 0;
logic [3:0] reg_addr_i = '0;
logic [23:0] reg_wdata_i = '0;
logic reg_wr_i = 0;
logic reg_rd_i = 0;
logic presc_clr_o, pc_load_o, return_o, tbl_rd_o, tbl_wr_o;
logic [20:0] pc_target_o, tbl_addr_o;
logic [23:0] reg_rdata_o;
mlt_fwr_type file_wr_o;
int n_errors = 0;
int n_checks = 0;
int cyc = 0;
logic [23:0] q[$];
logic rd_seen = 0;
logic [7:0] w = 0;
logic [7:0] k, src;
logic [4:0] st = 0;
logic [3:0] bank;
logic [20:0] pc = '0;
logic [20:0] p;
logic [11:0] ptr2;
logic [7:0] ops [8] = '{OP_MOVE_LIT, OP_ADD_LIT, OP_SUB_LIT, OP_AND_LIT,
    OP_OR_LIT, OP_XOR_LIT, OP_MUL_LIT, OP_RET_LIT};
logic [7:0] offs [3] = '{8'h80, 8'h7f, 8'h01};

mlt_core dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_pc_i(instr_pc_i), .instr_ready_o(), .file_raddr_o(), .file_rdata_i(file_rdata_i),
    .file_wr_o(file_wr_o), .port_pins_i(port_pins_i), .presc_clr_o(presc_clr_o),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .return_o(return_o), .tbl_rd_o(tbl_rd_o),
    .tbl_wr_o(tbl_wr_o), .tbl_addr_o(tbl_addr_o), .tbl_wdata_o(), .tbl_rdata_i(tbl_rdata_i),
    .mem_wr_active_o(), .mem_wr_done_i(mem_wr_done_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o)
);

always #10 mclk_i = ~mclk_i;

task automatic end_sim;
    if (n_errors == 0 && n_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        n_errors++;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
endtask

// oldest note against each result; an unexpected result mismatches
task automatic take(input logic [23:0] got);
    if (q.size() == 0)
        chk(got, 24'hzzzzzz);
    else
        chk(got, q.pop_front());
endtask

task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
endtask

task automatic rd(input logic [3:0] a, input logic [23:0] d);
    @(posedge mclk_i);
    q.push_back(d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
endtask

// one word, then a spare cycle for the nop of two-cycle ops
task automatic ex(input logic [15:0] i, input bit e, input logic [23:0] x);
    @(posedge mclk_i);
    if (e)
        q.push_back(x);
    instr_i <= i;
    instr_pc_i <= pc;
    instr_valid_i <= 1'b1;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    instr_i <= ~i;
    @(posedge mclk_i);
endtask

task automatic zn(input logic [7:0] r);
    w = r;
    st[ST_N] = r[7];
    st[ST_Z] = (r == 8'h00);
endtask

task automatic addm(input logic [7:0] x, input logic [7:0] y, output logic [7:0] s);
    {st[ST_C], s} = {1'b0, x} + {1'b0, y};
    st[ST_DC] = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
    st[ST_OV] = (x[7] == y[7]) && (s[7] != x[7]);
    st[ST_N] = s[7];
    st[ST_Z] = (s == 8'h00);
endtask

task automatic lit(input logic [7:0] op, input logic [7:0] kk);
    logic [7:0] s;
    logic [15:0] pr;
    pr = 16'(w) * 16'(kk);
    s = kk - w;
    case (op)
        OP_ADD_LIT: addm(w, kk, w);
        OP_SUB_LIT:
        begin
            st[ST_C] = kk >= w;
            st[ST_DC] = kk[3:0] >= w[3:0];
            st[ST_OV] = (kk[7] != w[7]) && (s[7] != kk[7]);
            zn(s);
        end
        OP_AND_LIT: zn(w & kk);
        OP_OR_LIT: zn(w | kk);
        OP_XOR_LIT: zn(w ^ kk);
        OP_MUL_LIT: ;
        default: w = kk;
    endcase
    ex({op, kk}, op == OP_RET_LIT, 24'h1);
    rd(RA_WORK, {16'h0, w});
    rd(RA_STAT, {19'h0, st});
    if (op == OP_MUL_LIT)
    begin
        rd(RA_PRODL, {16'h0, pr[7:0]});
        rd(RA_PRODUCT_HIGH_BYTE, {16'h0, pr[15:8]});
    end
endtask

always @(posedge mclk_i) rd_seen <= reg_rd_i;

always @(negedge mclk_i)
    if (!rst_i)
    begin
        if (rd_seen)
            take(reg_rdata_o);
        if (file_wr_o.we)
            take({3'h0, presc_clr_o, file_wr_o.addr, file_wr_o.data});
        if (pc_load_o)
            take({3'h0, pc_target_o});
        if (return_o)
            take({23'h0, return_o});
        if (tbl_rd_o || tbl_wr_o)
            take({1'b0, tbl_rd_o, tbl_wr_o, tbl_addr_o});
    end

always @(posedge mclk_i)
begin
    cyc++;
    if (cyc == 6000)
    begin
        n_errors++;
        end_sim;
    end
end

initial
begin
    void'($urandom(16315));
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    port_pins_i <= 8'($urandom);
    lit(OP_MOVE_LIT, 8'h7f);
    lit(OP_ADD_LIT, 8'h01);
    lit(OP_MOVE_LIT, 8'hff);
    lit(OP_ADD_LIT, 8'h01);
    for (int r = 0; r < 3; r++)
        foreach (ops[j])
            lit(ops[j], 8'($urandom));
    bank = 4'($urandom);
    ex({OP_BANK_LIT, OP_BANK_MID, bank}, 0, '0);
    rd(RA_BANK, {20'h0, bank});
    for (int b = 0; b < 8; b++)
    begin
        src = 8'($urandom);
        file_rdata_i <= src;
        ex({OP_BIT_CLR, 3'(b), b[0], 8'h90}, 1,
            {4'h0, b[0] ? bank : ACCESS_HI, 8'h90, src & ~(8'h01 << b)});
    end
    file_rdata_i <= ~port_pins_i;
    ex({OP_BIT_CLR, 4'h0, 8'h81}, 1, {4'h0, PORT_ADDR, port_pins_i & 8'hfe});
    wr(RA_CTRL, 24'h2);
    ex({OP_BIT_CLR, 4'h2, 8'hd6}, 1, {4'h1, TIMER0_ADDR, ~port_pins_i & 8'hfd});
    src = 8'($urandom);
    file_rdata_i <= src;
    addm(w, src, k);
    ex({OP_ADD_FILE, 2'b10, 8'ha0}, 1, {4'h0, ACCESS_HI, 8'ha0, k});
    rd(RA_STAT, {19'h0, st});
    addm(w, src, w);
    ex({OP_ADD_FILE, 2'b00, 8'hd6}, 0, '0);
    rd(RA_WORK, {16'h0, w});
    wr(RA_CTRL, 24'h0);
    ptr2 = 12'($urandom);
    ex({OP_LOAD_PTR, 4'h2, ptr2[11:8]}, 0, '0);
    ex({OP_LOAD_PTR2, ptr2[7:0]}, 0, '0);
    rd(RA_PTR2, {12'h0, ptr2});
    ex({OP_LOAD_PTR2, 8'($urandom)}, 0, '0);
    rd(RA_PTR2, {12'h0, ptr2});
    rd(RA_WORK, {16'h0, w});
    wr(RA_CTRL, 24'h1);
    ex({OP_BIT_CLR, 4'he, IDX_LIMIT}, 1, {4'h0, ptr2 + 12'h05f, src & 8'h7f});
    wr(RA_CTRL, 24'h0);
    lit(OP_MOVE_LIT, 8'h80);
    lit(OP_AND_LIT, 8'hff);
    foreach (offs[j])
    begin
        pc = 21'($urandom) & 21'h1ffffe;
        ex({OP_BR_NEG, offs[j]}, 1,
            {3'h0, pc + PC_STEP + {{12{offs[j][7]}}, offs[j], 1'b0}});
    end
    lit(OP_AND_LIT, 8'h7f);
    ex({OP_BR_NEG, 8'h10}, 0, '0);
    p = 21'($urandom);
    wr(RA_TBLPTR, {3'h0, p});
    for (int m = 0; m < 8; m++)
    begin
        tbl_rdata_i <= 8'($urandom);
        ex(16'h0008 + 16'(m), 1,
            {1'b0, m < 4, m >= 4, (m % 4 == 3) ? p + 21'h1 : p});
        p = (m % 2 == 1) ? p + 21'h1 : (m % 4 == 2) ? p - 21'h1 : p;
        rd(RA_TBLPTR, {3'h0, p});
        if (m < 4)
            rd(RA_TBLAT, {16'h0, tbl_rdata_i});
    end
    rd(RA_MEMWR, 24'h1);
    @(posedge mclk_i);
    mem_wr_done_i <= 1'b1;
    @(posedge mclk_i);
    mem_wr_done_i <= 1'b0;
    rd(RA_MEMWR, 24'h0);
    rd(4'hc, 24'h0);
    repeat (4) @(posedge mclk_i);
    chk(24'(q.size()), 24'h0);
    end_sim;
end
endmodule
`default_nettype wire
